//--- bench/sbi_ctrl_model.sv
`timescale 1ns/1ps
module sbi_ctrl_model (
	input wire logic i_clock,
	input sbi_pkg::sbi_bank_st_t [sbi_pkg::BANKS-1:0] i_bank_state,
	input wire logic [sbi_pkg::BANK_W-1:0] i_burst_bank,
	output logic o_cke,
	output logic o_cs_n,
	output logic o_ras_n,
	output logic o_cas_n,
	output logic o_we_n,
	output logic [sbi_pkg::BANK_W-1:0] o_bank,
	output logic o_auto_precharge,
	output logic o_dqm
);
	import sbi_pkg::*;
	initial begin
		o_cke = 1'b1;
		o_cs_n = 1'b0;
		{o_ras_n, o_cas_n, o_we_n} = PAT_NOP;
		o_bank = '0;
		o_auto_precharge = 1'b0;
		o_dqm = 1'b0;
	end
	// one command per edge, launched just after the edge
	task automatic cmd(input sbi_cmd_t c, input int b, input logic ap, input logic dqm,
		input logic cke);
		logic [2:0] pat;
		sbi_cmd_t k;
		k = c;
		// refresh or mode load only with every bank idle, else hold off with a nop
		if ((c == CMD_REFRESH || c == CMD_MODE_LOAD) && i_bank_state != '0) begin
			k = CMD_NOP;
		end
		// an open or busy bank takes no new activate
		if (c == CMD_ACTIVE && i_bank_state[b] != ST_IDLE) begin
			k = CMD_NOP;
		end
		case (k)
			CMD_ACTIVE: pat = PAT_ACTIVE;
			CMD_READ: pat = PAT_READ;
			CMD_WRITE: pat = PAT_WRITE;
			CMD_PRECHARGE: pat = PAT_PRECHARGE;
			CMD_BST: pat = PAT_BST;
			CMD_REFRESH: pat = PAT_REFRESH;
			CMD_MODE_LOAD: pat = 3'h0;
			default: pat = PAT_NOP;
		endcase
		@(posedge i_clock);
		#1;
		o_cke <= cke;
		o_cs_n <= (k == CMD_INHIBIT);
		// deselected strobes carry no stale pattern
		{o_ras_n, o_cas_n, o_we_n} <= (k == CMD_INHIBIT) ? ~{o_ras_n, o_cas_n, o_we_n} : pat;
		// terminate only ever aims at the bank holding the burst
		o_bank <= (k == CMD_BST) ? i_burst_bank : BANK_W'(b);
		o_auto_precharge <= ap;
		o_dqm <= dqm;
	endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import sbi_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	wire logic cke, cs_n, ras_n, cas_n, we_n, ap, dqm;
	wire logic [BANK_W-1:0] bank;
	sbi_bank_st_t [BANKS-1:0] st;
	sbi_pwr_t mode;
	logic [BANK_W-1:0] bbank;
	logic bact, rdrv, wcap;
	int mismatches = 0;
	int checked = 0;
	always #12.5 clock = ~clock;
	sbi_ctrl_model sbi_ctrl_model_i (.i_clock(clock), .i_bank_state(st), .i_burst_bank(bbank),
		.o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
		.o_bank(bank), .o_auto_precharge(ap), .o_dqm(dqm));
	// long burst so suspend and interrupts land well inside it
	sbi_device #(.READ_LATENCY(2), .BURST_LEN(8)) sbi_device_i (.i_clock(clock),
		.i_resetn(resetn), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
		.i_we_n(we_n), .i_bank(bank), .i_auto_precharge(ap), .i_dqm(dqm),
		.o_bank_state(st), .o_power_mode(mode), .o_burst_bank(bbank),
		.o_burst_active(bact), .o_read_drive(rdrv), .o_write_capture(wcap));
	task automatic end_sim();
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic c(input sbi_cmd_t k, input int b = 0, input logic a = 1'b0,
		input logic m = 1'b0, input logic e = 1'b1);
		sbi_ctrl_model_i.cmd(k, b, a, m, e);
	endtask
	task automatic nops(input int n);
		repeat (n) c(CMD_NOP);
	endtask
	// bounded wait; running out counts as a failure and ends the run
	task automatic wait_idle(input int b, input int n);
		int i;
		i = 0;
		while (st[b] !== ST_IDLE && i < n) begin
			c(CMD_NOP);
			i++;
		end
		chk(st[b], ST_IDLE);
		if (st[b] !== ST_IDLE)
			end_sim();
	endtask
	task automatic open2(input int a, input int b);
		c(CMD_ACTIVE, a);
		c(CMD_ACTIVE, b);
		nops(ACTIVATE_CYC + 2);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		#1;
		resetn = 1'b1;
		nops(2);
		open2(0, 1);
		c(CMD_READ, 0);
		c(CMD_READ, 1);
		c(CMD_NOP);
		chk(st[0], ST_ACTIVE);
		chk(bbank, 2'h1);
		chk(rdrv, 1'b1);
		c(CMD_NOP, 0, 1'b0, 1'b1);
		c(CMD_WRITE, 0);
		c(CMD_NOP);
		chk(st[1], ST_ACTIVE);
		chk(wcap, 1'b1);
		c(CMD_NOP);
		chk(rdrv, 1'b0);
		c(CMD_READ, 1);
		c(CMD_NOP);
		chk(st[0], ST_ACTIVE);
		chk(wcap, 1'b0);
		c(CMD_WRITE, 0);
		c(CMD_WRITE, 1);
		c(CMD_NOP);
		chk(st[0], ST_ACTIVE);
		chk(wcap, 1'b1);
		c(CMD_WRITE, 0, 1'b1);
		c(CMD_WRITE, 1);
		c(CMD_NOP);
		chk(st[0] == ST_IDLE, 1'b0);
		wait_idle(0, WRITE_RECOVERY_CYC + PRECHARGE_CYC + 2);
		open2(0, 1);
		c(CMD_WRITE, 0, 1'b1);
		c(CMD_READ, 1);
		wait_idle(0, WRITE_RECOVERY_CYC + PRECHARGE_CYC + 2);
		open2(0, 1);
		c(CMD_READ, 1, 1'b1);
		c(CMD_READ, 0);
		c(CMD_NOP);
		chk(st[1], ST_READ_AP);
		nops(PRECHARGE_CYC);
		chk(st[1], ST_IDLE);
		wait_idle(1, PRECHARGE_CYC + 1);
		open2(1, 2);
		c(CMD_READ, 1, 1'b1);
		c(CMD_NOP, 0, 1'b0, 1'b1);
		c(CMD_NOP, 0, 1'b0, 1'b1);
		chk(rdrv, 1'b1);
		c(CMD_WRITE, 0);
		chk(rdrv, 1'b0);
		c(CMD_NOP);
		chk(st[1], ST_READ_AP);
		nops(PRECHARGE_CYC);
		chk(st[1], ST_IDLE);
		c(CMD_PRECHARGE, 0, 1'b1);
		nops(PRECHARGE_CYC + 3);
		chk(st == '0, 1'b1);
		c(CMD_NOP, 0, 1'b0, 1'b0, 1'b0);
		c(CMD_READ, 0, 1'b0, 1'b0, 1'b0);
		chk(mode, PWR_DOWN);
		c(CMD_NOP, 0, 1'b0, 1'b0, 1'b0);
		chk(mode, PWR_DOWN);
		chk(st[0], ST_IDLE);
		c(CMD_NOP);
		c(CMD_ACTIVE, 2);
		chk(mode, PWR_NORMAL);
		c(CMD_NOP);
		chk(st[2] == ST_IDLE, 1'b0);
		nops(ACTIVATE_CYC + 1);
		c(CMD_PRECHARGE, 2);
		wait_idle(2, PRECHARGE_CYC + 2);
		c(CMD_REFRESH, 0, 1'b0, 1'b0, 1'b0);
		c(CMD_INHIBIT, 0, 1'b0, 1'b0, 1'b0);
		chk(mode, PWR_SELF_REFRESH);
		c(CMD_NOP);
		c(CMD_NOP);
		chk(mode, PWR_SR_EXIT);
		nops(SELF_REFRESH_EXIT_CYC + 1);
		chk(mode, PWR_NORMAL);
		c(CMD_ACTIVE, 0);
		nops(ACTIVATE_CYC + 2);
		c(CMD_READ, 0);
		c(CMD_NOP, 0, 1'b0, 1'b0, 1'b0);
		c(CMD_NOP, 0, 1'b0, 1'b0, 1'b0);
		chk(mode, PWR_SUSPEND);
		chk(bact, 1'b1);
		c(CMD_NOP);
		c(CMD_BST, 3);
		chk(mode, PWR_NORMAL);
		c(CMD_NOP);
		chk(bact, 1'b0);
		chk(st[0], ST_ACTIVE);
		chk(st[3], ST_IDLE);
		end_sim();
	end
endmodule

//--- verilog/sbi_bank.sv
`timescale 1ns/1ps
module sbi_bank (
	input wire logic i_clock,
	input wire logic i_resetn,
	sbi_bank_if.bank bif
);
	import sbi_pkg::*;
	typedef struct packed {
		sbi_bank_st_t st;
		sbi_phase_t ph;
		logic [CNT_W-1:0] cnt;
	} sbi_bank_reg_t;
	localparam sbi_bank_reg_t BANK_RESET = '0;
	sbi_bank_reg_t s;
	sbi_bank_reg_t next_s;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	assign bif.state = s.st;

	always_comb begin
		next_s = s;
		if (s.cnt != '0) begin
			next_s.cnt = s.cnt - 1'b1;
		end
		case (s.st)
		ST_IDLE: begin
			if (bif.act) begin
				next_s.st = ST_ACTIVATING;
				next_s.cnt = ACTIVATE_CYC - 1'b1;
			end
		end
		ST_ACTIVATING: begin
			if (s.cnt == '0) begin
				next_s.st = ST_ACTIVE;
			end
		end
		ST_ACTIVE, ST_READ, ST_WRITE: begin
			if (bif.rd) begin
				next_s.ph = PH_BURST;
				next_s.st = bif.ap ? ST_READ_AP : ST_READ;
			end else if (bif.wr) begin
				next_s.ph = PH_BURST;
				next_s.st = bif.ap ? ST_WRITE_AP : ST_WRITE;
			end else if (bif.pre) begin
				next_s.st = ST_PRECHARGING;
				next_s.cnt = PRECHARGE_CYC - 1'b1;
			end else if (bif.stop) begin
				next_s.st = ST_ACTIVE;
			end
		end
		ST_READ_AP, ST_WRITE_AP: begin
			case (s.ph)
			PH_BURST: begin
				if (bif.stop && s.st == ST_WRITE_AP) begin
					next_s.ph = PH_RECOVER;
					next_s.cnt = WRITE_RECOVERY_CYC - 1'b1;
				end else if (bif.stop) begin
					next_s.ph = PH_PRECHARGE;
					next_s.cnt = PRECHARGE_CYC - 1'b1;
				end
			end
			PH_RECOVER: begin
				if (s.cnt == '0) begin
					next_s.ph = PH_PRECHARGE;
					next_s.cnt = PRECHARGE_CYC - 1'b1;
				end
			end
			default: begin
				if (s.cnt == '0) begin
					next_s.st = ST_IDLE;
					next_s.ph = PH_BURST;
				end
			end
			endcase
		end
		ST_PRECHARGING: begin
			if (s.cnt == '0) begin
				next_s.st = ST_IDLE;
			end
		end
		default: begin
			next_s = BANK_RESET;
		end
		endcase
		// gated internal clock freezes every timer too
		if (bif.hold) begin
			next_s = s;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			s <= BANK_RESET;
		end else begin
			s <= next_s;
		end
	end

	sequence s_wap_cut;
		s.st == ST_WRITE_AP && s.ph == PH_BURST && bif.stop && !bif.hold;
	endsequence
	sequence s_rap_cut;
		s.st == ST_READ_AP && s.ph == PH_BURST && bif.stop && !bif.hold;
	endsequence

	a_wap_recover: assert property (
		s_wap_cut |=> s.ph == PH_RECOVER && s.cnt == WRITE_RECOVERY_CYC - 1'b1)
		else $error("write recovery not started at interrupt");
	a_rap_precharge: assert property (
		s_rap_cut |=> s.ph == PH_PRECHARGE && s.cnt == PRECHARGE_CYC - 1'b1)
		else $error("read auto precharge not started at interrupt");
	a_ap_to_idle: assert property (
		(s.st == ST_READ_AP || s.st == ST_WRITE_AP) && s.ph == PH_PRECHARGE
		&& s.cnt == '0 && !bif.hold |=> s.st == ST_IDLE)
		else $error("auto precharge bank did not go idle");
endmodule

//--- verilog/sbi_bank_if.sv
`timescale 1ns/1ps
interface sbi_bank_if;
	logic act;
	logic rd;
	logic wr;
	logic pre;
	logic ap;
	logic stop;
	logic hold;
	sbi_pkg::sbi_bank_st_t state;
	modport ctrl (output act, rd, wr, pre, ap, stop, hold, input state);
	modport bank (input act, rd, wr, pre, ap, stop, hold, output state);
endinterface

//--- verilog/sbi_device.sv
`timescale 1ns/1ps
module sbi_device #(
	parameter int READ_LATENCY = 2,
	parameter int BURST_LEN = 4
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_cke,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [sbi_pkg::BANK_W-1:0] i_bank,
	input wire logic i_auto_precharge,
	input wire logic i_dqm,
	output sbi_pkg::sbi_bank_st_t [sbi_pkg::BANKS-1:0] o_bank_state,
	output sbi_pkg::sbi_pwr_t o_power_mode,
	output logic [sbi_pkg::BANK_W-1:0] o_burst_bank,
	output logic o_burst_active,
	output logic o_read_drive,
	output logic o_write_capture
);
	import sbi_pkg::*;
	localparam int LEFT_W = $clog2(BURST_LEN + 1);
	typedef logic [READ_LATENCY-1:0] sbi_rpipe_t;
	typedef struct packed {
		logic cke_prev;
		sbi_pwr_t pwr;
		logic [CNT_W-1:0] xcnt;
		logic [BANK_W-1:0] owner;
		logic owner_wr;
		logic bursting;
		logic [LEFT_W-1:0] left;
		sbi_rpipe_t rpipe;
		logic dqm_d;
		logic drive;
		logic capture;
	} sbi_dev_reg_t;
	// all banks idle, normal power after initialization
	localparam sbi_dev_reg_t DEV_RESET = '0;

	sbi_dev_reg_t s;
	sbi_dev_reg_t next_s;
	sbi_cmd_t cmd;
	logic nop;
	logic ready;
	logic run;
	logic rdwr;
	logic word;
	logic all_idle;
	logic [BANKS-1:0] idle_vec;
	logic [BANKS-1:0] go_act;
	logic [BANKS-1:0] go_rd;
	logic [BANKS-1:0] go_wr;
	logic [BANKS-1:0] go_pre;
	logic [BANKS-1:0] go_stop;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	function automatic sbi_cmd_t decode(
		input logic cs_n,
		input logic [2:0] pat
	);
		sbi_cmd_t c;
		c = CMD_MODE_LOAD;
		if (cs_n) begin
			c = CMD_INHIBIT;
		end else begin
			case (pat)
			PAT_NOP: begin
				c = CMD_NOP;
			end
			PAT_ACTIVE: begin
				c = CMD_ACTIVE;
			end
			PAT_READ: begin
				c = CMD_READ;
			end
			PAT_WRITE: begin
				c = CMD_WRITE;
			end
			PAT_PRECHARGE: begin
				c = CMD_PRECHARGE;
			end
			PAT_BST: begin
				c = CMD_BST;
			end
			PAT_REFRESH: begin
				c = CMD_REFRESH;
			end
			default: begin
				c = CMD_MODE_LOAD;
			end
			endcase
		end
		return c;
	endfunction

	sbi_bank_if bif [BANKS] ();

	generate
		for (genvar g = 0; g < BANKS; g++) begin : g_bank
			assign bif[g].act = go_act[g];
			assign bif[g].rd = go_rd[g];
			assign bif[g].wr = go_wr[g];
			assign bif[g].pre = go_pre[g];
			assign bif[g].stop = go_stop[g];
			assign bif[g].ap = i_auto_precharge;
			assign bif[g].hold = !i_cke;
			assign o_bank_state[g] = bif[g].state;
			assign idle_vec[g] = bif[g].state == ST_IDLE;
			sbi_bank u_bank (
				.i_clock(i_clock),
				.i_resetn(i_resetn),
				.bif(bif[g])
			);
		end
	endgenerate

	assign all_idle = &idle_vec;
	assign o_power_mode = s.pwr;
	assign o_burst_bank = s.owner;
	assign o_burst_active = s.bursting;
	assign o_read_drive = s.drive;
	assign o_write_capture = s.capture;

	always_comb begin
		next_s = s;
		go_act = '0;
		go_rd = '0;
		go_wr = '0;
		go_pre = '0;
		go_stop = '0;
		word = 1'b0;
		cmd = decode(i_cs_n, {i_ras_n, i_cas_n, i_we_n});
		nop = cmd == CMD_NOP || cmd == CMD_INHIBIT;
		// self refresh exit ignores commands until its period ends
		ready = s.pwr == PWR_NORMAL || (s.pwr == PWR_SR_EXIT && s.xcnt == '0);
		run = ready && s.cke_prev && i_cke;
		rdwr = run && (cmd == CMD_READ || cmd == CMD_WRITE);
		next_s.cke_prev = i_cke;
		next_s.dqm_d = i_dqm;

		case ({s.cke_prev, i_cke})
		2'b10: begin
			if (ready && all_idle && nop) begin
				next_s.pwr = PWR_DOWN;
			end else if (ready && all_idle && cmd == CMD_REFRESH) begin
				next_s.pwr = PWR_SELF_REFRESH;
			end else if (ready && s.bursting) begin
				next_s.pwr = PWR_SUSPEND;
			end
		end
		2'b01: begin
			if (s.pwr == PWR_DOWN && nop) begin
				next_s.pwr = PWR_NORMAL;
			end else if (s.pwr == PWR_SELF_REFRESH && nop) begin
				next_s.pwr = PWR_SR_EXIT;
				next_s.xcnt = SELF_REFRESH_EXIT_CYC - 1'b1;
			end else if (s.pwr == PWR_SUSPEND) begin
				next_s.pwr = PWR_NORMAL;
			end
		end
		2'b11: begin
			if (s.pwr == PWR_SR_EXIT && s.xcnt == '0) begin
				next_s.pwr = PWR_NORMAL;
			end else if (s.pwr == PWR_SR_EXIT) begin
				next_s.xcnt = s.xcnt - 1'b1;
			end
		end
		default: begin
			next_s.pwr = s.pwr;
		end
		endcase

		// activate, read, write and precharge reach only their addressed bank, except precharge with auto precharge set, which reaches every bank
		if (run) begin
			case (cmd)
			CMD_ACTIVE: begin
				go_act[i_bank] = 1'b1;
			end
			CMD_READ: begin
				go_rd[i_bank] = 1'b1;
			end
			CMD_WRITE: begin
				go_wr[i_bank] = 1'b1;
			end
			CMD_PRECHARGE: begin
				if (i_auto_precharge) begin
					go_pre = '1;
				end else begin
					go_pre[i_bank] = 1'b1;
				end
			end
			default: begin
				go_pre = '0;
			end
			endcase
		end

		if (!i_cke) begin
			// suspended: burst and read pipe frozen, no write data taken
			next_s.capture = 1'b0;
		end else begin
			if (rdwr) begin
				if (s.bursting && s.owner != i_bank) begin
					go_stop[s.owner] = 1'b1;
				end
				next_s.owner = i_bank;
				next_s.owner_wr = cmd == CMD_WRITE;
				next_s.bursting = 1'b1;
				next_s.left = LEFT_W'(BURST_LEN - 1);
				word = 1'b1;
			end else if (s.bursting && run && cmd == CMD_BST) begin
				go_stop[s.owner] = 1'b1;
				next_s.bursting = 1'b0;
			end else if (s.bursting && run && cmd == CMD_PRECHARGE
				&& (i_auto_precharge || i_bank == s.owner)) begin
				next_s.bursting = 1'b0;
			end else if (s.bursting) begin
				word = 1'b1;
				next_s.left = s.left - 1'b1;
				if (s.left == LEFT_W'(1)) begin
					go_stop[s.owner] = 1'b1;
					next_s.bursting = 1'b0;
				end
			end
			// read words surface one latency after their edge
			next_s.rpipe = sbi_rpipe_t'({s.rpipe, word && !next_s.owner_wr});
			if (rdwr && cmd == CMD_WRITE) begin
				next_s.rpipe = '0;
			end
			next_s.capture = word && next_s.owner_wr && !i_dqm;
			// mask acts two edges late on reads, hence the delayed copy
			next_s.drive = next_s.rpipe[READ_LATENCY-1] && !s.dqm_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			s <= DEV_RESET;
		end else begin
			s <= next_s;
		end
	end

	sequence s_pd_leave;
		s.pwr == PWR_DOWN && !s.cke_prev && i_cke && nop;
	endsequence
	sequence s_susp_leave;
		s.pwr == PWR_SUSPEND && !s.cke_prev && i_cke;
	endsequence
	sequence s_sr_leave;
		s.pwr == PWR_SELF_REFRESH && !s.cke_prev && i_cke && nop;
	endsequence

	a_pd_entry: assert property (
		s.pwr == PWR_NORMAL && s.cke_prev && !i_cke && all_idle && nop
		|=> o_power_mode == PWR_DOWN)
		else $error("power-down not entered");
	a_sr_entry: assert property (
		s.pwr == PWR_NORMAL && s.cke_prev && !i_cke && all_idle
		&& cmd == CMD_REFRESH |=> o_power_mode == PWR_SELF_REFRESH)
		else $error("self refresh not entered");
	a_low_hold: assert property (
		!s.cke_prev && !i_cke |=> $stable(o_power_mode))
		else $error("low-power state changed with gate low");
	a_pd_exit: assert property (
		s_pd_leave |=> o_power_mode == PWR_NORMAL && all_idle)
		else $error("power-down exit failed");
	a_susp_exit: assert property (
		s_susp_leave |=> o_power_mode == PWR_NORMAL && $stable(o_burst_bank))
		else $error("clock suspend exit failed");
	a_sr_wait: assert property (
		s_sr_leave |=> o_power_mode == PWR_SR_EXIT
		&& s.xcnt == SELF_REFRESH_EXIT_CYC - 1'b1)
		else $error("self refresh exit period not started");
	a_wr_ends_rd: assert property (
		rdwr && cmd == CMD_WRITE |=> !o_read_drive ##0 o_burst_active)
		else $error("read data still driven after write");
	a_rd_ends_wr: assert property (
		rdwr && cmd == CMD_READ && s.bursting && s.owner_wr
		|=> !o_write_capture && o_burst_bank == $past(i_bank))
		else $error("write data taken after read");
	a_interrupt: assert property (
		rdwr && s.bursting && s.owner != i_bank |-> go_stop[s.owner])
		else $error("interrupted bank not stopped");
	a_bst_owner: assert property (
		run && cmd == CMD_BST && s.bursting
		|-> go_stop == (BANKS'(1) << s.owner))
		else $error("burst terminate reached wrong bank");
	a_rd_enters: assert property (
		rdwr && cmd == CMD_READ |=> s.rpipe[0] && o_burst_active)
		else $error("read word not queued for output");
	// a masked cycle must leave the data bus undriven
	a_mask_drive: assert property (
		s.dqm_d && i_cke |=> !o_read_drive)
		else $error("read data driven under mask");
	a_wr_ends_wr: assert property (
		rdwr && cmd == CMD_WRITE && s.bursting && s.owner_wr && s.owner != i_bank
		|=> o_burst_bank == $past(i_bank) && o_write_capture == !$past(i_dqm))
		else $error("interrupting write not captured");
endmodule

//--- verilog/sbi_pkg.sv
// Operation
// - burst terminate hits only current burst bank
// - auto precharge state lasts until precharge ends
// - interrupted auto precharge burst starts own precharge
// - read over read: new data after latency
// - write ends read; mask one clock before
// - read ends write; last word one clock earlier
// - write ends write; last word previous clock
// - read interrupting auto precharge read starts precharge
// - write ends auto precharge read; precharge starts
// - read over auto precharge write: recovery first
// - write over auto precharge write: recovery first
// - gate low twice keeps low-power state
// - gate falling selects power-down, refresh, suspend
// - gate rising with nop leaves power-down
// - suspend exit; next command following edge
// - command encoding on select and strobe inputs
package sbi_pkg;
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int CNT_W = 4;
	localparam int CLOCK_PERIOD_NS = 25;
	localparam int PRECHARGE_PERIOD_NS = 20;
	localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
	localparam int WRITE_RECOVERY_PERIOD_NS = 15;
	localparam int SELF_REFRESH_EXIT_PERIOD_NS = 75;
	localparam logic [CNT_W-1:0] PRECHARGE_CYC =
		CNT_W'((PRECHARGE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [CNT_W-1:0] ACTIVATE_CYC =
		CNT_W'((ACTIVATE_TO_ACCESS_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC =
		CNT_W'((WRITE_RECOVERY_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [CNT_W-1:0] SELF_REFRESH_EXIT_CYC =
		CNT_W'((SELF_REFRESH_EXIT_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	// row, column and write strobe patterns with select low
	localparam logic [2:0] PAT_NOP = 3'h7;
	localparam logic [2:0] PAT_ACTIVE = 3'h3;
	localparam logic [2:0] PAT_READ = 3'h5;
	localparam logic [2:0] PAT_WRITE = 3'h4;
	localparam logic [2:0] PAT_PRECHARGE = 3'h2;
	localparam logic [2:0] PAT_BST = 3'h6;
	localparam logic [2:0] PAT_REFRESH = 3'h1;
	typedef enum logic [3:0] {
		CMD_INHIBIT = 4'h0,
		CMD_NOP = 4'h1,
		CMD_ACTIVE = 4'h2,
		CMD_READ = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_PRECHARGE = 4'h5,
		CMD_BST = 4'h6,
		CMD_REFRESH = 4'h7,
		CMD_MODE_LOAD = 4'h8
	} sbi_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ACTIVATING = 3'h1,
		ST_ACTIVE = 3'h2,
		ST_READ = 3'h3,
		ST_WRITE = 3'h4,
		ST_READ_AP = 3'h5,
		ST_WRITE_AP = 3'h6,
		ST_PRECHARGING = 3'h7
	} sbi_bank_st_t;
	typedef enum logic [1:0] {
		PH_BURST = 2'h0,
		PH_RECOVER = 2'h1,
		PH_PRECHARGE = 2'h2
	} sbi_phase_t;
	typedef enum logic [2:0] {
		PWR_NORMAL = 3'h0,
		PWR_DOWN = 3'h1,
		PWR_SELF_REFRESH = 3'h2,
		PWR_SUSPEND = 3'h3,
		PWR_SR_EXIT = 3'h4
	} sbi_pwr_t;
endpackage
